// ===== sac_pkg.sv
// shared constants and types for the converter sequence control
package sac_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int RES_BITS = 8;

    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_RESULT = 8'hd0;
    localparam logic [7:0] IDX_CTRL = 8'hd1;
    localparam logic [1:0] BYTE_PAD = 2'h0;

    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam int BIT_IEN = 7;
    localparam int BIT_DONE = 6;
    localparam int BIT_GO = 5;
    localparam int BIT_PWR = 4;
    localparam int BYTE_LANE0 = 0;

    localparam logic [RES_BITS-1:0] MSB_MASK = 8'h80;

    // conversion timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CONV_DIV = 12;
    localparam int CONV_TIME_NS = 70_000;
    localparam int REF_OSC_HZ = 8_000_000;
    localparam int REF_OSC_MHZ = REF_OSC_HZ / 1_000_000;
    localparam int NS_PER_US = 1000;
    // oscillator cycles of one conversion, then conversion-clock ticks, then ticks per bit
    localparam int CONV_OSC_CYCLES = CONV_TIME_NS * REF_OSC_MHZ / NS_PER_US;
    localparam int CONV_TICKS = CONV_OSC_CYCLES / CONV_DIV;
    localparam int STEP_TICKS = (CONV_TICKS / RES_BITS < 1) ? 1 : CONV_TICKS / RES_BITS;

    typedef enum logic [0:0] {
        SAC_IDLE = 1'b0,
        SAC_RUN  = 1'b1
    } sac_state_e;

endpackage

// ===== sac_step_if.sv
// carrier between the register side and the approximation core
`timescale 1ns/1ns
interface sac_step_if;
    import sac_pkg::*;

    logic                start;
    logic                abort;
    logic                hold;
    logic                comp;
    logic                busy;
    logic                done;
    logic [RES_BITS-1:0] trial;
    logic [RES_BITS-1:0] result;

    modport ctl (output start, abort, hold, comp, input busy, done, trial, result);
    modport core (input start, abort, hold, comp, output busy, done, trial, result);
endinterface

// ===== sac_sar_core.sv
// successive approximation engine on the divided conversion clock
`timescale 1ns/1ns
module sac_sar_core
    import sac_pkg::*;
#(
    parameter int DIV  = CONV_DIV,
    parameter int STEP = STEP_TICKS
) (
    input wire logic  clk,  // system clock
    input wire logic  rst,  // synchronous reset, high
    sac_step_if.core  sif   // control side
);
    localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam int SW = (STEP > 1) ? $clog2(STEP) : 1;

    sac_state_e          state_reg;
    logic [DW-1:0]       div_reg;
    logic [SW-1:0]       step_reg;
    logic [RES_BITS-1:0] mask_reg;
    logic [RES_BITS-1:0] trial_reg;
    logic [RES_BITS-1:0] result_reg;
    logic                done_reg;

    wire running  = (state_reg == SAC_RUN);
    wire div_wrap = (div_reg == DW'(DIV - 1));
    // hold only stops the tick; the divider parks at its last count
    wire conv_tick = running && div_wrap && !sif.hold;
    wire step_end  = conv_tick && (step_reg == SW'(STEP - 1));
    wire [RES_BITS-1:0] mask_next = mask_reg >> 1;
    wire [RES_BITS-1:0] decided = sif.comp ? trial_reg : (trial_reg & ~mask_reg);
    wire last_bit = mask_reg[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg  <= SAC_IDLE;
            div_reg    <= '0;
            step_reg   <= '0;
            mask_reg   <= '0;
            trial_reg  <= '0;
            result_reg <= '0;
            done_reg   <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (sif.start) begin
                state_reg <= SAC_RUN;
                div_reg   <= '0;
                step_reg  <= '0;
                mask_reg  <= MSB_MASK;
                trial_reg <= MSB_MASK;
            end else if (sif.abort) begin
                state_reg <= SAC_IDLE;
                trial_reg <= '0;
            end else if (running) begin
                if (!div_wrap) begin
                    div_reg <= div_reg + DW'(1);
                end else if (!sif.hold) begin
                    div_reg <= '0;
                end
                if (conv_tick) begin
                    step_reg <= step_end ? '0 : step_reg + SW'(1);
                end
                if (step_end && last_bit) begin
                    result_reg <= decided;
                    trial_reg  <= decided;
                    done_reg   <= 1'b1;
                    state_reg  <= SAC_IDLE;
                end else if (step_end) begin
                    mask_reg  <= mask_next;
                    trial_reg <= decided | mask_next;
                end
            end
        end
    end

    assign sif.busy   = running;
    assign sif.done   = done_reg;
    assign sif.trial  = trial_reg;
    assign sif.result = result_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_step_spacing;
        running && !sif.start && !sif.abort && !sif.hold && div_reg == '0 |=>
            !step_end [*1];
    endproperty
    a_step_spacing: assert property (p_step_spacing) else $error("bit decided too soon after divider wrap");

    property p_held_frozen;
        running && sif.hold && !sif.start && !sif.abort |=> $stable(trial_reg) && $stable(step_reg);
    endproperty
    a_held_frozen: assert property (p_held_frozen) else $error("approximation advanced while held");
endmodule

// ===== sac_control.sv
// converter control register, bus slave and conversion sequencing
`timescale 1ns/1ns
module sac_control
    import sac_pkg::*;
#(
    parameter int DIV  = CONV_DIV,
    parameter int STEP = STEP_TICKS
) (
    input  wire logic                clk,              // system clock, 20 MHz
    input  wire logic                rst,              // synchronous reset, high
    input  wire logic [ADDR_W-1:0]   avs_address,      // byte address
    input  wire logic                avs_read,         // read request
    input  wire logic                avs_write,        // write request
    input  wire logic [DATA_W-1:0]   avs_writedata,    // write data
    input  wire logic [3:0]          avs_byteenable,   // byte lanes
    output logic      [DATA_W-1:0]   avs_readdata,     // read data
    output logic                     avs_waitrequest,  // stall
    input  wire logic                comp_in,          // analog comparator, asynchronous
    input  wire logic                core_in_wait,     // core has entered wait state
    input  wire logic                wait_sync_opt,    // wait-synchronised start option
    output logic [RES_BITS-1:0]      dac_code,         // trial code to the analog array
    output logic                     analog_power_on,  // converter supply enable
    output logic                     conv_active,      // conversion running
    output logic                     done_irq          // completion request, vector four
);
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        hit = (addr == {idx, BYTE_PAD});
    endfunction

    sac_step_if sif ();

    sac_sar_core #(
        .DIV  (DIV),
        .STEP (STEP)
    ) u_core (
        .clk (clk),
        .rst (rst),
        .sif (sif.core)
    );

    logic                comp_meta_reg;
    logic                comp_sync_reg;
    logic                done_irq_enable_reg;
    logic                analog_power_on_reg;
    logic                done_reg;
    logic                done_next;
    logic                hold_reg;
    logic                hold_next;
    logic                wait_reg;
    logic [DATA_W-1:0]   rdata_reg;
    logic                irq_reg;
    logic                active_reg;
    logic [RES_BITS-1:0] dac_reg;

    // bus decode: first edge of a request latches the answer, the second completes it
    wire req      = avs_read | avs_write;
    wire take     = req & wait_reg;
    wire complete = req & ~wait_reg;
    wire sel_ctrl = hit(avs_address, IDX_CTRL);
    wire sel_res  = hit(avs_address, IDX_RESULT);
    wire wr_ctrl  = avs_write & complete & sel_ctrl & avs_byteenable[BYTE_LANE0];
    wire wr_go    = wr_ctrl & avs_writedata[BIT_GO];
    // a start while unpowered is refused; only the done clear happens
    wire go_start = wr_go & analog_power_on_reg;
    wire next_ien = avs_writedata[BIT_IEN];
    wire next_pwr = avs_writedata[BIT_PWR];

    // go is never stored, so it always reads zero along with bits 3..0
    wire [RES_BITS-1:0] ctrl_view =
        (RES_BITS'(done_irq_enable_reg) << BIT_IEN) |
        (RES_BITS'(done_reg) << BIT_DONE) |
        (RES_BITS'(analog_power_on_reg) << BIT_PWR);

    wire [DATA_W-1:0] rd_mux = sel_ctrl ? DATA_W'(ctrl_view) :
                               sel_res  ? DATA_W'(sif.result) : '0;

    // a completion in the same cycle as a go write still sets the flag
    assign done_next = sif.done ? 1'b1 : (wr_go ? 1'b0 : done_reg);

    // hold is cleared by the core actually reaching wait, never by time
    assign hold_next = go_start ? (wait_sync_opt & ~core_in_wait) :
                       (core_in_wait ? 1'b0 : hold_reg);

    assign sif.start = go_start;
    assign sif.abort = ~analog_power_on_reg;
    assign sif.hold  = hold_reg;
    assign sif.comp  = comp_sync_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end else begin
            comp_meta_reg <= comp_in;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    // wait state does not touch power; only a software write or reset clears it
    always_ff @(posedge clk) begin
        if (rst) begin
            done_irq_enable_reg <= CTRL_RESET[BIT_IEN];
            analog_power_on_reg <= CTRL_RESET[BIT_PWR];
            done_reg            <= CTRL_RESET[BIT_DONE];
            hold_reg            <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                done_irq_enable_reg <= next_ien;
                analog_power_on_reg <= next_pwr;
            end
            done_reg <= done_next;
            hold_reg <= hold_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_reg  <= 1'b1;
            rdata_reg <= '0;
        end else begin
            wait_reg <= ~take;
            if (take) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // nothing here looks at wait except the hold, so completion can wake the core
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_reg    <= 1'b0;
            active_reg <= 1'b0;
            dac_reg    <= '0;
        end else begin
            irq_reg    <= done_reg & done_irq_enable_reg;
            active_reg <= sif.busy;
            dac_reg    <= sif.trial;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign done_irq        = irq_reg;
    assign conv_active     = active_reg;
    assign dac_code        = dac_reg;
    assign analog_power_on = analog_power_on_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_go_clears;
        wr_go && !sif.done |=> !done_reg;
    endproperty
    a_go_clears: assert property (p_go_clears) else $error("done not cleared by go write");

    property p_done_sets;
        sif.done |=> done_reg ##1 (done_irq == $past(done_irq_enable_reg));
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done flag not set on completion");

    property p_single_shot;
        sif.done && !sif.start ##1 !sif.start |-> !sif.busy [*2];
    endproperty
    a_single_shot: assert property (p_single_shot) else $error("conversion restarted on its own");

    property p_restart;
        go_start |=> sif.busy && sif.trial == MSB_MASK;
    endproperty
    a_restart: assert property (p_restart) else $error("go did not start a fresh conversion");

    property p_go_reads_zero;
        take && sel_ctrl |=> avs_readdata[BIT_GO] == 1'b0 && avs_readdata[3:0] == 4'h0;
    endproperty
    a_go_reads_zero: assert property (p_go_reads_zero) else $error("write-only or unused bits read nonzero");

    property p_irq_on_done;
        done_reg && done_irq_enable_reg |=> done_irq;
    endproperty
    a_irq_on_done: assert property (p_irq_on_done) else $error("completion request missing");

    property p_irq_masked;
        !done_irq_enable_reg |=> !done_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("request raised while masked");

    property p_power_off;
        !analog_power_on_reg |=> !sif.busy ##1 !conv_active;
    endproperty
    a_power_off: assert property (p_power_off) else $error("converter ran while powered down");

    property p_reset_value;
        $fell(rst) |-> done_reg && !done_irq_enable_reg && !analog_power_on_reg && !sif.busy;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("control not at reset value");

    property p_read_keeps_done;
        done_reg && !wr_go |=> done_reg;
    endproperty
    a_read_keeps_done: assert property (p_read_keeps_done) else $error("done lost without a go write");

    property p_answer_time;
        take |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_answer_time: assert property (p_answer_time) else $error("bus answer not one cycle after take");

    property p_hold_set;
        go_start && wait_sync_opt && !core_in_wait |=> hold_reg;
    endproperty
    a_hold_set: assert property (p_hold_set) else $error("synced start not held");

    property p_hold_release;
        hold_reg && core_in_wait && !go_start |=> !hold_reg;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold kept after core reached wait");

    property p_run_in_wait;
        sif.busy && core_in_wait && analog_power_on_reg |=> sif.busy || sif.done;
    endproperty
    a_run_in_wait: assert property (p_run_in_wait) else $error("conversion stopped in wait state");

    property p_ien_write;
        wr_ctrl |=> done_irq_enable_reg == $past(avs_writedata[BIT_IEN]);
    endproperty
    a_ien_write: assert property (p_ien_write) else $error("enable bit not taken from write");

    property p_pwr_write;
        wr_ctrl |=> analog_power_on_reg == $past(avs_writedata[BIT_PWR]);
    endproperty
    a_pwr_write: assert property (p_pwr_write) else $error("power bit not taken from write");

    property p_ctrl_kept;
        !wr_ctrl |=> $stable(analog_power_on_reg) && $stable(done_irq_enable_reg);
    endproperty
    a_ctrl_kept: assert property (p_ctrl_kept) else $error("control bits changed without a write");

    property p_done_source;
        $rose(done_reg) && !$past(rst) |-> $past(sif.done);
    endproperty
    a_done_source: assert property (p_done_source) else $error("done set without a completion");

    property p_irq_follows_flag;
        !done_reg |=> !done_irq;
    endproperty
    a_irq_follows_flag: assert property (p_irq_follows_flag) else $error("request raised without done");

    property p_result_kept;
        $changed(sif.result) && !$past(rst) |-> sif.done;
    endproperty
    a_result_kept: assert property (p_result_kept) else $error("result changed outside completion");

    property p_result_read;
        take && sel_res |=> avs_readdata == DATA_W'($past(sif.result));
    endproperty
    a_result_read: assert property (p_result_read) else $error("result read differs from stored result");

    property p_upper_zero;
        take |=> avs_readdata[DATA_W-1:RES_BITS] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read lanes nonzero");

    property p_refused_go;
        wr_go && !analog_power_on_reg |=> !sif.busy;
    endproperty
    a_refused_go: assert property (p_refused_go) else $error("conversion ran while unpowered");

    property p_dac_follows;
        1'b1 |=> dac_code == $past(sif.trial);
    endproperty
    a_dac_follows: assert property (p_dac_follows) else $error("trial code output lags wrongly");

    property p_active_follows;
        1'b1 |=> conv_active == $past(sif.busy);
    endproperty
    a_active_follows: assert property (p_active_follows) else $error("running flag lags wrongly");

    property p_busy_from_go;
        $rose(sif.busy) |-> $past(go_start);
    endproperty
    a_busy_from_go: assert property (p_busy_from_go) else $error("conversion began without a go write");
endmodule

// ===== sac_control_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module sac_control_tb;
    import sac_pkg::*;
    localparam logic [ADDR_W-1:0] A_CTL = {IDX_CTRL, BYTE_PAD};
    localparam logic [ADDR_W-1:0] A_RES = {IDX_RESULT, BYTE_PAD};
    localparam logic [ADDR_W-1:0] A_BAD = 10'h0100;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic [ADDR_W-1:0]   adr = '0;
    logic                rd = 1'b0;
    logic                wr = 1'b0;
    logic [DATA_W-1:0]   wd = '0;
    logic [DATA_W-1:0]   rdata;
    logic                wreq;
    logic                comp_in = 1'b0;
    logic                in_wait = 1'b0;
    logic                sync_opt = 1'b0;
    logic [RES_BITS-1:0] dac_code;
    logic                pwr;
    logic                active;
    logic                irq;
    logic [7:0]          ain = 8'h00;
    logic [3:0]          be = 4'hf;
    logic [DATA_W-1:0]   d;
    int                  failures = 0;
    int                  cmp_count = 0;

    // small divider keeps each conversion short; comparator path has slack
    sac_control #(.DIV(4), .STEP(2)) i_sac_control (
        .clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .comp_in(comp_in), .core_in_wait(in_wait),
        .wait_sync_opt(sync_opt), .dac_code(dac_code), .analog_power_on(pwr),
        .conv_active(active), .done_irq(irq));

    initial begin
        forever #25 clk = ~clk;
    end

    // ideal comparator: keep the bit while the input is at or above the trial
    always @(posedge clk) comp_in <= (ain >= dac_code);

    function automatic logic [DATA_W-1:0] ctl(input logic ien, input logic dn, input logic pw);
        return {24'h0000_00, ien, dn, 1'b0, pw, 4'h0};
    endfunction

    task automatic check(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
                       output logic [DATA_W-1:0] q);
        int n;
        @(posedge clk);
        adr <= a;
        wd <= v;
        rd <= ~w;
        wr <= w;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 50) begin
            failures++;
            results();
        end
    endtask

    task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        bus(1'b0, a, '0, d);
        check(nm, d, exp);
    endtask

    task automatic wait_done;
        int n;
        for (n = 0; n < 400; n++) begin
            bus(1'b0, A_CTL, '0, d);
            if (d[BIT_DONE] === 1'b1) break;
        end
        if (n == 400) begin
            failures++;
            results();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    initial begin
        logic ien;
        void'($urandom(32'h2e45));
        cyc(16);
        rst <= 1'b0;
        cyc(1);
        rdchk("ctl_reset", A_CTL, ctl(1'b0, 1'b1, 1'b0));
        check("pwr_reset", 32'(pwr), 32'h0000_0000);
        rdchk("unmapped", A_BAD, '0);
        bus(1'b1, A_RES, 32'h0000_00a5, d);
        rdchk("res_ro", A_RES, '0);
        bus(1'b1, A_CTL, 32'h0000_001f, d);
        rdchk("ctl_unused", A_CTL, ctl(1'b0, 1'b1, 1'b1));
        check("pwr_on", 32'(pwr), 32'h0000_0001);
        // lane 0 disabled: the write must leave the control bits alone
        be <= 4'he;
        bus(1'b1, A_CTL, 32'h0000_0080, d);
        be <= 4'hf;
        rdchk("lane_off", A_CTL, ctl(1'b0, 1'b1, 1'b1));
        $display("test registers done");

        for (int i = 0; i < 12; i++) begin
            ain <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom());
            ien = 1'($urandom());
            bus(1'b1, A_CTL, 32'(ctl(ien, 1'b0, 1'b1)) | 32'h0000_0020, d);
            rdchk("done_clr", A_CTL, ctl(ien, 1'b0, 1'b1));
            wait_done();
            rdchk("result", A_RES, 32'(ain));
            cyc(2);
            check("irq", 32'(irq), 32'(ien));
            rdchk("done_stays", A_CTL, ctl(ien, 1'b1, 1'b1));
            cyc(120);
            check("one_shot", 32'(active), 32'h0000_0000);
            bus(1'b1, A_CTL, 32'(ctl(1'b0, 1'b0, 1'b1)), d);
            cyc(2);
            check("irq_mask", 32'(irq), 32'h0000_0000);
        end
        $display("test conversions done");

        ain <= 8'h3c;
        bus(1'b1, A_CTL, 32'h0000_0030, d);
        cyc(20);
        ain <= 8'hc3;
        bus(1'b1, A_CTL, 32'h0000_0030, d);
        wait_done();
        rdchk("restart", A_RES, 32'h0000_00c3);
        $display("test restart done");

        bus(1'b1, A_CTL, 32'h0000_0030, d);
        cyc(10);
        bus(1'b1, A_CTL, 32'h0000_0000, d);
        cyc(3);
        check("off_active", 32'(active), 32'h0000_0000);
        check("off_pwr", 32'(pwr), 32'h0000_0000);
        rdchk("off_keep", A_RES, 32'h0000_00c3);
        rdchk("off_ctl", A_CTL, ctl(1'b0, 1'b0, 1'b0));
        $display("test power down done");

        bus(1'b1, A_CTL, 32'h0000_0010, d);
        ain <= 8'h5a;
        sync_opt <= 1'b1;
        bus(1'b1, A_CTL, 32'h0000_00b0, d);
        cyc(150);
        check("held_irq", 32'(irq), 32'h0000_0000);
        rdchk("held_done", A_CTL, ctl(1'b1, 1'b0, 1'b1));
        in_wait <= 1'b1;
        wait_done();
        cyc(2);
        check("wait_irq", 32'(irq), 32'h0000_0001);
        check("wait_pwr", 32'(pwr), 32'h0000_0001);
        rdchk("wait_res", A_RES, 32'h0000_005a);
        in_wait <= 1'b0;
        sync_opt <= 1'b0;
        $display("test wait sync done");

        bus(1'b1, A_CTL, 32'h0000_00b0, d);
        cyc(10);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        check("rst_active", 32'(active), 32'h0000_0000);
        check("rst_irq", 32'(irq), 32'h0000_0000);
        rdchk("rst_ctl", A_CTL, ctl(1'b0, 1'b1, 1'b0));
        $display("test reset abort done");
        results();
    end

    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        results();
    end
endmodule
